// file: core/gpt16_pkg.sv
// Constants shared by the gated 16-bit timer
package gpt16_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_COUNT_VALUE = 16'h0100;
  localparam logic [15:0] ADDR_PERIOD_VALUE = 16'h0102;
  localparam logic [15:0] ADDR_TIMER_CONTROL = 16'h0104;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0106;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0108;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int TIMER_ON_POS = 15;
  localparam int IDLE_STOP_POS = 13;
  localparam int GATE_ACC_POS = 6;
  localparam int PRESC_HI_POS = 5;
  localparam int PRESC_LO_POS = 4;
  localparam int EXT_SYNC_POS = 2;
  localparam int CLK_SRC_POS = 1;
  localparam logic [15:0] CONTROL_WMASK = 16'hA076;

  // ----------------------------------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_MATCH_POS = 0;
  localparam int IRQ_GATE_POS = 1;
  localparam int IRQ_BITS = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // ----------------------------------------------------------------
  // Prescaler terminal counts and instruction-cycle divider
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESC_SEL_1 = 2'h0;
  localparam logic [1:0] PRESC_SEL_8 = 2'h1;
  localparam logic [1:0] PRESC_SEL_64 = 2'h2;
  localparam logic [7:0] PRESC_LAST_1 = 8'h00;
  localparam logic [7:0] PRESC_LAST_8 = 8'h07;
  localparam logic [7:0] PRESC_LAST_64 = 8'h3F;
  localparam logic [7:0] PRESC_LAST_256 = 8'hFF;
  localparam logic [1:0] TCY_LAST = 2'h3;

endpackage

// file: core/gpt16_timer.sv
// Gated 16-bit timer/counter with prescaler, idle/sleep control and interrupt
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module gpt16_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Processor power state
  input wire logic idle_i,
  input wire logic sleep_i,
  // External clock or gate pin
  input wire logic ext_clock_gate_pin_i,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] count_value_q;
  logic [15:0] period_value_q;
  logic [15:0] timer_control_q;
  logic [gpt16_pkg::IRQ_BITS-1:0] irq_flag_status_q;
  logic [gpt16_pkg::IRQ_BITS-1:0] irq_enable_control_q;
  logic [15:0] rdata_q;
  logic irq_q;
  logic [7:0] presc_q;
  logic [1:0] tcy_q;
  logic pin_sync1_q;
  logic pin_sync2_q;
  logic pin_sync3_q;
  logic pin_raw_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  assign wr_count = wr_i && (addr_i == gpt16_pkg::ADDR_COUNT_VALUE);
  assign wr_period = wr_i && (addr_i == gpt16_pkg::ADDR_PERIOD_VALUE);
  assign wr_control = wr_i && (addr_i == gpt16_pkg::ADDR_TIMER_CONTROL);
  assign wr_status = wr_i && (addr_i == gpt16_pkg::ADDR_IRQ_STATUS);
  assign wr_mask = wr_i && (addr_i == gpt16_pkg::ADDR_IRQ_MASK);

  logic timer_on_bit;
  logic idle_stop_bit;
  logic gate_accumulate_enable;
  logic [1:0] prescale_select;
  logic external_sync_select;
  logic clock_source_select;
  assign timer_on_bit = timer_control_q[gpt16_pkg::TIMER_ON_POS];
  assign idle_stop_bit = timer_control_q[gpt16_pkg::IDLE_STOP_POS];
  assign gate_accumulate_enable = timer_control_q[gpt16_pkg::GATE_ACC_POS];
  assign prescale_select =
    timer_control_q[gpt16_pkg::PRESC_HI_POS:gpt16_pkg::PRESC_LO_POS];
  assign external_sync_select = timer_control_q[gpt16_pkg::EXT_SYNC_POS];
  assign clock_source_select = timer_control_q[gpt16_pkg::CLK_SRC_POS];

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  logic tcy_tick;
  logic gate_mode;
  logic sync_rise;
  logic raw_rise;
  logic gate_fall;
  logic src_tick;
  assign tcy_tick = (tcy_q == gpt16_pkg::TCY_LAST);
  assign gate_mode = gate_accumulate_enable && !clock_source_select;
  // Edge detection looks only at the second and third stages
  assign sync_rise = pin_sync2_q && !pin_sync3_q;
  // Pin is already clock-synchronous, so raw mode skips the two stages
  assign raw_rise = ext_clock_gate_pin_i && !pin_raw_q;
  assign gate_fall = !pin_sync2_q && pin_sync3_q;

  always_comb
  begin
    if (!clock_source_select)
      src_tick = tcy_tick && (!gate_accumulate_enable || pin_sync2_q);
    else if (external_sync_select)
      src_tick = sync_rise;
    else
      src_tick = raw_rise;
  end

  // Running conditions for idle and sleep
  logic async_ext;
  logic run;
  assign async_ext = clock_source_select && !external_sync_select;
  assign run = timer_on_bit
    && !(idle_i && idle_stop_bit)
    && !(sleep_i && !async_ext);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [7:0] presc_last;
  logic presc_tick;
  always_comb
  begin
    case (prescale_select)
      gpt16_pkg::PRESC_SEL_1: presc_last = gpt16_pkg::PRESC_LAST_1;
      gpt16_pkg::PRESC_SEL_8: presc_last = gpt16_pkg::PRESC_LAST_8;
      gpt16_pkg::PRESC_SEL_64: presc_last = gpt16_pkg::PRESC_LAST_64;
      default: presc_last = gpt16_pkg::PRESC_LAST_256;
    endcase
  end
  assign presc_tick = run && src_tick && (presc_q >= presc_last);

  logic ton_clear;
  assign ton_clear = wr_control && !wdata_i[gpt16_pkg::TIMER_ON_POS];

  always_ff @(posedge clk_i)
  begin
    if (srst_i || wr_count || ton_clear)
      presc_q <= 8'h00;
    else if (run && src_tick)
      presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
    // Prescaler holds its value while the timer is off, except that a count write or a control write with TON clear zeroes it
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      tcy_q <= 2'h0;
    else
      tcy_q <= tcy_q + 2'h1;
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
      pin_sync3_q <= 1'b0;
      pin_raw_q <= 1'b0;
    end
    else
    begin
      pin_sync1_q <= ext_clock_gate_pin_i;
      pin_sync2_q <= pin_sync1_q;
      pin_sync3_q <= pin_sync2_q;
      pin_raw_q <= ext_clock_gate_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic match_evt;
  logic gate_evt;
  assign match_evt = presc_tick && (count_value_q == period_value_q);
  assign gate_evt = timer_on_bit && gate_mode && gate_fall;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      count_value_q <= gpt16_pkg::COUNT_RESET;
    else if (wr_count)
      count_value_q <= gpt16_pkg::COUNT_RESET;
    else if (match_evt)
      count_value_q <= gpt16_pkg::COUNT_RESET;
    else if (presc_tick)
      count_value_q <= count_value_q + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      period_value_q <= gpt16_pkg::PERIOD_RESET;
    else if (wr_period)
      period_value_q <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      timer_control_q <= gpt16_pkg::CONTROL_RESET;
    else if (wr_control)
      timer_control_q <= wdata_i & gpt16_pkg::CONTROL_WMASK;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [gpt16_pkg::IRQ_BITS-1:0] irq_set;
  logic [gpt16_pkg::IRQ_BITS-1:0] irq_clr;
  always_comb
  begin
    irq_set = '0;
    irq_set[gpt16_pkg::IRQ_MATCH_POS] = match_evt;
    irq_set[gpt16_pkg::IRQ_GATE_POS] = gate_evt;
    irq_clr = wr_status ? wdata_i[gpt16_pkg::IRQ_BITS-1:0] : '0;
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      irq_flag_status_q <= '0;
    else
      irq_flag_status_q <= (irq_flag_status_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      irq_enable_control_q <= '0;
    else if (wr_mask)
      irq_enable_control_q <= wdata_i[gpt16_pkg::IRQ_BITS-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_flag_status_q & irq_enable_control_q);
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !rd_i)
      rdata_q <= gpt16_pkg::READ_IDLE;
    else
    begin
      case (addr_i)
        gpt16_pkg::ADDR_COUNT_VALUE: rdata_q <= count_value_q;
        gpt16_pkg::ADDR_PERIOD_VALUE: rdata_q <= period_value_q;
        gpt16_pkg::ADDR_TIMER_CONTROL: rdata_q <= timer_control_q;
        gpt16_pkg::ADDR_IRQ_STATUS: rdata_q <= {14'h0000, irq_flag_status_q};
        gpt16_pkg::ADDR_IRQ_MASK: rdata_q <= {14'h0000, irq_enable_control_q};
        default: rdata_q <= gpt16_pkg::READ_IDLE;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_wrap;
    @(posedge clk_i) disable iff (srst_i)
    (presc_tick && !wr_count && count_value_q == period_value_q)
      |=> (count_value_q == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

  property p_incr;
    @(posedge clk_i) disable iff (srst_i)
    (presc_tick && !wr_count && count_value_q != period_value_q)
      |=> (count_value_q == $past(count_value_q) + 16'h0001);
  endproperty
  a_incr: assert property (p_incr) else $error("count did not advance");

  property p_idle_hold;
    @(posedge clk_i) disable iff (srst_i)
    (idle_i && idle_stop_bit && !wr_count) |=> $stable(count_value_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle");

  property p_sleep_hold;
    @(posedge clk_i) disable iff (srst_i)
    (sleep_i && !async_ext && !wr_count) |=> $stable(count_value_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_presc_clr;
    @(posedge clk_i) disable iff (srst_i)
    (wr_count || ton_clear) |=> (presc_q == 8'h00);
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

  property p_presc_off;
    @(posedge clk_i) disable iff (srst_i)
    (!timer_on_bit && !wr_count && !ton_clear) |=> $stable(presc_q);
  endproperty
  a_presc_off: assert property (p_presc_off) else $error("prescaler moved while off");

  property p_presc_range;
    @(posedge clk_i) disable iff (srst_i)
    (run && src_tick && (presc_q >= presc_last)) |=> (presc_q == 8'h00);
  endproperty
  a_presc_range: assert property (p_presc_range) else $error("prescaler overran");

  property p_ctrl_keep;
    @(posedge clk_i) disable iff (srst_i)
    (wr_control && !presc_tick) |=> $stable(count_value_q);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved count");

  property p_gate_low;
    @(posedge clk_i) disable iff (srst_i)
    (gate_mode && !pin_sync2_q && !wr_count) |=> $stable(count_value_q);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("counted with gate low");

  property p_flag_set;
    @(posedge clk_i) disable iff (srst_i)
    (match_evt || gate_evt) |=> ((irq_flag_status_q & $past(irq_set)) == $past(irq_set));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on event");

  property p_flag_hold;
    @(posedge clk_i) disable iff (srst_i)
    (irq_flag_status_q[gpt16_pkg::IRQ_MATCH_POS] && !wr_status)
      |=> irq_flag_status_q[gpt16_pkg::IRQ_MATCH_POS];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");

  property p_irq_gate;
    @(posedge clk_i) disable iff (srst_i)
    match_evt ##1 irq_enable_control_q[gpt16_pkg::IRQ_MATCH_POS] |=> irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("enabled match gave no irq");

  c_wrap: cover property (@(posedge clk_i) disable iff (srst_i) match_evt);
  c_gate_fall: cover property (@(posedge clk_i) disable iff (srst_i) gate_evt);
  c_sleep_count: cover property (@(posedge clk_i) disable iff (srst_i)
    sleep_i && presc_tick);
  c_irq: cover property (@(posedge clk_i) disable iff (srst_i) $rose(irq_o));

endmodule

`default_nettype wire

// file: test/gpt16_ext_src.sv
// External clock or gate source driving the timer pin
`timescale 1ns/1ps
`default_nettype none
module gpt16_ext_src (
  // Clock
  input wire logic clk_i,
  // Burst request
  input wire logic start_i,
  input wire logic [9:0] pulses_i,
  input wire logic [7:0] half_i,
  // Pin side
  output logic pin_o,
  output logic busy_o
);
  logic [9:0] left_q = 10'h000;
  logic [7:0] tick_q = 8'h00;
  logic pin_q = 1'b0;
  assign busy_o = (left_q != 10'h000);
  assign pin_o = pin_q;
  // Pin rests low between bursts, as a stopped clock would
  always @(posedge clk_i)
  begin
    if (start_i)
    begin
      left_q <= pulses_i;
      tick_q <= 8'h00;
      pin_q <= 1'b0;
    end
    else if (busy_o && tick_q == half_i)
    begin
      tick_q <= 8'h00;
      pin_q <= ~pin_q;
      left_q <= left_q - {9'h000, pin_q};
    end
    else if (busy_o)
    begin
      tick_q <= tick_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the gated 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle_i = 1'b0;
  logic sleep_i = 1'b0;
  logic start = 1'b0;
  logic [9:0] pulses = 10'h000;
  logic [7:0] half = 8'h00;
  logic [15:0] rdata_o;
  logic irq_o;
  logic pin;
  logic busy;
  logic [15:0] v;
  int n_errors = 0;
  int checks = 0;
  gpt16_timer gpt16_timer_inst (.clk_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
    .sleep_i(sleep_i), .ext_clock_gate_pin_i(pin), .irq_o(irq_o));
  gpt16_ext_src gpt16_ext_src_inst (.clk_i(clock_i), .start_i(start), .pulses_i(pulses),
    .half_i(half), .pin_o(pin), .busy_o(busy));
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic tmo(input logic ok);
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  // ----------------------------------------------------------------
  // Bus and pin drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    // Take the data mid-cycle, while it stands, and return on an edge
    @(negedge clock_i);
    d = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic burst(input logic [9:0] n, input logic [7:0] h);
    int i;
    @(posedge clock_i);
    pulses <= n;
    half <= h;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    @(posedge clock_i);
    for (i = 0; i < 20000 && busy; i++)
      @(posedge clock_i);
    tmo(!busy);
    repeat (6) @(posedge clock_i);
  endtask
  task automatic ext_count(input logic [15:0] ctl, input logic [9:0] n, input logic [15:0] exp);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, ctl & 16'h7FFF);
    wr(gpt16_pkg::ADDR_COUNT_VALUE, 16'h0000);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, ctl);
    burst(n, 8'h03);
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk(v, exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk(v, 16'h0000);
    rd(gpt16_pkg::ADDR_PERIOD_VALUE, v);
    chk(v, 16'hFFFF);
    rd(gpt16_pkg::ADDR_IRQ_STATUS, v);
    chk(v, 16'h0000);
    rd(16'h010A, v);
    chk(v, 16'h0000);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'hFFFF);
    rd(gpt16_pkg::ADDR_TIMER_CONTROL, v);
    chk(v, 16'hA076);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'h0000);
  endtask
  task automatic t_timer();
    int i;
    wr(gpt16_pkg::ADDR_PERIOD_VALUE, 16'h0002);
    wr(gpt16_pkg::ADDR_IRQ_MASK, 16'h0001);
    wr(gpt16_pkg::ADDR_COUNT_VALUE, 16'h0000);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'h8000);
    for (i = 0; i < 64 && irq_o !== 1'b1; i++)
      @(posedge clock_i);
    tmo(irq_o === 1'b1);
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk_rng(v, 16'h0000, 16'h0002);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'h0000);
    repeat (20) @(posedge clock_i);
    rd(gpt16_pkg::ADDR_IRQ_STATUS, v);
    chk(v, 16'h0001);
    wr(gpt16_pkg::ADDR_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clock_i);
    chk({15'h0000, irq_o}, 16'h0000);
    wr(gpt16_pkg::ADDR_IRQ_STATUS, 16'h0001);
    rd(gpt16_pkg::ADDR_IRQ_STATUS, v);
    chk(v, 16'h0000);
    wr(gpt16_pkg::ADDR_PERIOD_VALUE, 16'hFFFF);
  endtask
  task automatic t_presc();
    logic [9:0] np [4] = '{10'h005, 10'h010, 10'h080, 10'h100};
    logic [15:0] ex [4] = '{16'h0005, 16'h0002, 16'h0002, 16'h0001};
    int s;
    for (s = 0; s < 4; s++)
      ext_count(16'h8002 | 16'(s << 4), np[s], ex[s]);
  endtask
  task automatic t_modes();
    ext_count(16'h8006, 10'h004, 16'h0004);
    idle_i <= 1'b1;
    ext_count(16'h8002, 10'h004, 16'h0004);
    ext_count(16'hA006, 10'h004, 16'h0000);
    ext_count(16'hA002, 10'h004, 16'h0000);
    // Halted in idle: counting must pick up again once idle ends
    idle_i <= 1'b0;
    burst(10'h003, 8'h03);
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk(v, 16'h0003);
  endtask
  task automatic t_sleep();
    wr(gpt16_pkg::ADDR_PERIOD_VALUE, 16'h0003);
    wr(gpt16_pkg::ADDR_IRQ_MASK, 16'h0001);
    sleep_i <= 1'b1;
    ext_count(16'h8002, 10'h005, 16'h0001);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'h0012);
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk(v, 16'h0001);
    ext_count(16'h8006, 10'h004, 16'h0000);
    ext_count(16'h8000, 10'h004, 16'h0000);
    sleep_i <= 1'b0;
    wr(gpt16_pkg::ADDR_IRQ_STATUS, 16'h0003);
    wr(gpt16_pkg::ADDR_PERIOD_VALUE, 16'hFFFF);
  endtask
  task automatic t_gate();
    wr(gpt16_pkg::ADDR_IRQ_MASK, 16'h0002);
    wr(gpt16_pkg::ADDR_COUNT_VALUE, 16'h0000);
    wr(gpt16_pkg::ADDR_TIMER_CONTROL, 16'h8040);
    repeat (40) @(posedge clock_i);
    burst(10'h001, 8'h27);
    rd(gpt16_pkg::ADDR_COUNT_VALUE, v);
    chk_rng(v, 16'h0008, 16'h000B);
    rd(gpt16_pkg::ADDR_IRQ_STATUS, v);
    chk(v, 16'h0002);
    chk({15'h0000, irq_o}, 16'h0001);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial
  begin
    forever #10 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_timer();
    t_presc();
    t_modes();
    t_sleep();
    t_gate();
    wrap_up();
  end
endmodule
`default_nettype wire
